// ==== ccr_map.svh ====
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// ============================================================
// Command codes and byte indices
`define CCR_CMD_BASE 8'h80
`define CCR_IDX_STATUS 3'h0
`define CCR_IDX_FIRST_RW 3'h3
`define CCR_IDX_B3 3'h3
`define CCR_IDX_B4 3'h4
`define CCR_IDX_B5 3'h5
`define CCR_IDX_B6 3'h6
`define CCR_IDX_B7 3'h7

// ============================================================
// Power-up values
`define CCR_B3_RST 8'h00
`define CCR_B4_RST 8'h27
`define CCR_B5_RST 8'hff
`define CCR_B6_RST 8'hf0
`define CCR_B7_RST 8'h89

// ============================================================
// Field positions
`define CCR_OVR_BIT 5
`define CCR_PH_MSB 4
`define CCR_DIVEN_BIT 5
`define CCR_BYP_BIT 4
`define CCR_SEL_MSB 3
`define CCR_CHIP_EN_BIT 7
`define CCR_EN_HI_MSB 6
`define CCR_EN_LO_MSB 7
`define CCR_EN_LO_LSB 4
`define CCR_BW_MSB 3
`define CCR_PLL_EN_BIT 7
`define CCR_M_MSB 5
`define CCR_M_LSB 4
`define CCR_N_MSB 3
`define CCR_GROUP0_LAST 4
`define CCR_BW_EXTERNAL 4'h1

// ============================================================
// Bus framing
`define CCR_BITS_PER_BYTE 4'h8

`endif

// ==== ccr_pkg.sv ====
`default_nettype none

package ccr_pkg;

  typedef logic [7:0] ccr_byte_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_CMD,
    ST_CACK,
    ST_WDATA,
    ST_WACK,
    ST_RDATA,
    ST_RACK
  } ccr_state_e;

  typedef struct packed {
    logic lock_status;
    logic lock_gate_override;
    logic [4:0] group0_phase_select;
    logic group0_divider_enable;
    logic group0_bypass;
    logic [3:0] group0_ratio_select;
    logic [6:0] group0_ratio;
    logic chip_enable;
    logic quiescent_powerdown;
    logic [10:0] output_enable;
    logic [10:0] output_active;
    logic [3:0] loop_bandwidth_select;
    logic external_loop_filter;
    logic synth_loop_enable;
    logic [1:0] input_divider_select;
    logic [3:0] input_ratio;
    logic [3:0] feedback_divider_select;
    logic [5:0] feedback_ratio;
  } ccr_cfg_s;

endpackage

`default_nettype wire

// ==== ccr_config_regs.sv ====
// Functional notes
// - Override bit 5 of byte 3 stops lock gating of outputs; resets 0.
// - Byte 3 bits 4..0 set first-group phase; reset zero.
// - Byte 4 bit 5 zero disables outputs 0..4; resets 1.
// - Byte 4 bit 4 picks input clock (1) or loop clock (0); resets 0.
// - Byte 4 bits 3..0 pick first-group ratio; reset 0111.
// - Byte 5 bit 7 zero puts chip in quiescent power-down; resets 1.
// - Per-output enables in byte 5 bits 6..0 and byte 6 bits 7..4, reset 1.
// - Byte 6 bits 3..0 set loop bandwidth; value 1 means external filter.
// - Byte 7 bit 7 zero switches loop off; resets 1.
// - Byte 7 bits 5..4 select input divider; reset 00.
// - Byte 7 bits 3..0 select feedback divider; reset 1001.
// - Post-divider codes 0..10 map to 1,2,4,5,8,10,16,20,32,40,80.
// - Byte k is addressed by command code 80h plus k.
// - Read-only lock status reported and used for output gating.
// - Feedback pattern 1000 gives 32, 1001 gives 40.
// - Input divider 00,01,10,11 gives 1,2,4,8.
`include "ccr_map.svh"
`default_nettype none

module ccr_config_regs
  import ccr_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic pll_lock_in,
  output ccr_cfg_s cfg_out
);

  // ============================================================
  // Pin synchronisers
  // Pins are {lock, sda, scl}; a level counts once stages two and three agree.
  logic [2:0] pin_s1_reg, pin_s1_next;
  logic [2:0] pin_s2_reg, pin_s2_next;
  logic [2:0] pin_s3_reg, pin_s3_next;
  logic [2:0] filt_reg, filt_next;
  logic [2:0] prev_reg, prev_next;

  always_comb begin
    pin_s1_next = {pll_lock_in, sda_in, scl_in};
    pin_s2_next = pin_s1_reg;
    pin_s3_next = pin_s2_reg;
    prev_next = filt_reg;
    for (int i = 0; i < 3; i++) begin
      filt_next[i] = (pin_s2_reg[i] == pin_s3_reg[i]) ? pin_s3_reg[i] : filt_reg[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_s1_reg <= 3'h3;
      pin_s2_reg <= 3'h3;
      pin_s3_reg <= 3'h3;
      filt_reg <= 3'h3;
      prev_reg <= 3'h3;
    end else begin
      pin_s1_reg <= pin_s1_next;
      pin_s2_reg <= pin_s2_next;
      pin_s3_reg <= pin_s3_next;
      filt_reg <= filt_next;
      prev_reg <= prev_next;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic sda_f;

  assign sda_f = filt_reg[1];
  assign scl_rise = filt_reg[0] & ~prev_reg[0];
  assign scl_fall = ~filt_reg[0] & prev_reg[0];
  assign bus_start = filt_reg[0] & prev_reg[0] & prev_reg[1] & ~filt_reg[1];
  assign bus_stop = filt_reg[0] & prev_reg[0] & ~prev_reg[1] & filt_reg[1];

  // ============================================================
  // Configuration storage and decode helpers
  ccr_byte_t cfg_reg [`CCR_IDX_B7:`CCR_IDX_B3];
  ccr_byte_t cfg_next [`CCR_IDX_B7:`CCR_IDX_B3];

  // Bytes 1 and 2 are not held here and read as zero
  function automatic ccr_byte_t rd_byte(input logic [2:0] idx);
    ccr_byte_t val;
    val = 8'h00;
    if (idx >= `CCR_IDX_FIRST_RW) begin
      val = cfg_reg[idx];
    end else if (idx == `CCR_IDX_STATUS) begin
      val = {filt_reg[2], 7'h00};
    end
    return val;
  endfunction

  // Codes 11..15 give ratio 0 so nothing downstream sees a bogus value
  function automatic logic [6:0] post_ratio(input logic [3:0] sel);
    logic [6:0] r;
    r = 7'h00;
    unique case (sel)
      4'h0: r = 7'h01;
      4'h1: r = 7'h02;
      4'h2: r = 7'h04;
      4'h3: r = 7'h05;
      4'h4: r = 7'h08;
      4'h5: r = 7'h0a;
      4'h6: r = 7'h10;
      4'h7: r = 7'h14;
      4'h8: r = 7'h20;
      4'h9: r = 7'h28;
      4'ha: r = 7'h50;
      default: r = 7'h00;
    endcase
    return r;
  endfunction

  // ============================================================
  // Management bus slave
  ccr_state_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  ccr_byte_t shift_reg, shift_next;
  logic [2:0] idx_reg, idx_next;
  logic oe_reg, oe_next;
  logic rw_reg, rw_next;
  logic acked_reg, acked_next;

  always_comb begin
    ccr_byte_t rd_cur;
    ccr_byte_t rd_inc;
    rd_cur = rd_byte(idx_reg);
    rd_inc = rd_byte(3'(idx_reg + 3'h1));
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    idx_next = idx_reg;
    oe_next = oe_reg;
    rw_next = rw_reg;
    acked_next = acked_reg;
    cfg_next = cfg_reg;
    if (bus_stop) begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end else if (bus_start) begin
      state_next = ST_ADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          oe_next = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_f};
            cnt_next = 4'(cnt_reg + 4'h1);
          end else if (scl_fall && cnt_reg == `CCR_BITS_PER_BYTE) begin
            if (shift_reg[7:1] == SLAVE_ADDR) begin
              rw_next = shift_reg[0];
              oe_next = 1'b1;
              state_next = ST_AACK;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              shift_next = rd_cur;
              oe_next = ~rd_cur[7];
              cnt_next = 4'h1;
              state_next = ST_RDATA;
            end else begin
              oe_next = 1'b0;
              cnt_next = 4'h0;
              state_next = ST_CMD;
            end
          end
        end
        ST_CMD: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_f};
            cnt_next = 4'(cnt_reg + 4'h1);
          end else if (scl_fall && cnt_reg == `CCR_BITS_PER_BYTE) begin
            // Codes outside 80h..87h are not acknowledged
            if (shift_reg[7:3] == 5'(`CCR_CMD_BASE >> 3)) begin
              idx_next = shift_reg[2:0];
              oe_next = 1'b1;
              state_next = ST_CACK;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        ST_CACK, ST_WACK: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            cnt_next = 4'h0;
            state_next = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_f};
            cnt_next = 4'(cnt_reg + 4'h1);
          end else if (scl_fall && cnt_reg == `CCR_BITS_PER_BYTE) begin
            if (idx_reg >= `CCR_IDX_FIRST_RW) begin
              cfg_next[idx_reg] = shift_reg;
            end
            // Word writes land in byte k then k+1
            idx_next = 3'(idx_reg + 3'h1);
            oe_next = 1'b1;
            state_next = ST_WACK;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_reg == `CCR_BITS_PER_BYTE) begin
              oe_next = 1'b0;
              state_next = ST_RACK;
            end else begin
              oe_next = ~shift_reg[6];
              shift_next = {shift_reg[6:0], 1'b0};
              cnt_next = 4'(cnt_reg + 4'h1);
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            acked_next = ~sda_f;
          end else if (scl_fall) begin
            if (acked_reg) begin
              idx_next = 3'(idx_reg + 3'h1);
              shift_next = rd_inc;
              oe_next = ~rd_inc[7];
              cnt_next = 4'h1;
              state_next = ST_RDATA;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      idx_reg <= 3'h0;
      oe_reg <= 1'b0;
      rw_reg <= 1'b0;
      acked_reg <= 1'b0;
      cfg_reg[`CCR_IDX_B3] <= `CCR_B3_RST;
      cfg_reg[`CCR_IDX_B4] <= `CCR_B4_RST;
      cfg_reg[`CCR_IDX_B5] <= `CCR_B5_RST;
      cfg_reg[`CCR_IDX_B6] <= `CCR_B6_RST;
      cfg_reg[`CCR_IDX_B7] <= `CCR_B7_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      idx_reg <= idx_next;
      oe_reg <= oe_next;
      rw_reg <= rw_next;
      acked_reg <= acked_next;
      cfg_reg <= cfg_next;
    end
  end

  // ============================================================
  // Decoded configuration outputs
  ccr_cfg_s cfg_out_reg, cfg_out_next;
  logic sda_out_reg;

  always_comb begin
    ccr_cfg_s c;
    logic lock_ok;
    c = '0;
    lock_ok = 1'b0;
    c.lock_status = filt_reg[2];
    c.lock_gate_override = cfg_reg[`CCR_IDX_B3][`CCR_OVR_BIT];
    c.group0_phase_select = cfg_reg[`CCR_IDX_B3][`CCR_PH_MSB:0];
    c.group0_divider_enable = cfg_reg[`CCR_IDX_B4][`CCR_DIVEN_BIT];
    c.group0_bypass = cfg_reg[`CCR_IDX_B4][`CCR_BYP_BIT];
    c.group0_ratio_select = cfg_reg[`CCR_IDX_B4][`CCR_SEL_MSB:0];
    c.group0_ratio = post_ratio(c.group0_ratio_select);
    c.chip_enable = cfg_reg[`CCR_IDX_B5][`CCR_CHIP_EN_BIT];
    c.quiescent_powerdown = ~c.chip_enable;
    c.output_enable = {cfg_reg[`CCR_IDX_B5][`CCR_EN_HI_MSB:0],
                       cfg_reg[`CCR_IDX_B6][`CCR_EN_LO_MSB:`CCR_EN_LO_LSB]};
    c.loop_bandwidth_select = cfg_reg[`CCR_IDX_B6][`CCR_BW_MSB:0];
    c.external_loop_filter = (c.loop_bandwidth_select == `CCR_BW_EXTERNAL);
    c.synth_loop_enable = cfg_reg[`CCR_IDX_B7][`CCR_PLL_EN_BIT];
    c.input_divider_select = cfg_reg[`CCR_IDX_B7][`CCR_M_MSB:`CCR_M_LSB];
    c.input_ratio = 4'(4'h1 << c.input_divider_select);
    c.feedback_divider_select = cfg_reg[`CCR_IDX_B7][`CCR_N_MSB:0];
    unique case (c.feedback_divider_select)
      4'h8: c.feedback_ratio = 6'h20;
      4'h9: c.feedback_ratio = 6'h28;
      default: c.feedback_ratio = 6'h00;
    endcase
    // Gating uses the filtered lock so a one-cycle lock glitch cannot chop outputs
    lock_ok = c.lock_status | c.lock_gate_override;
    for (int i = 0; i < 11; i++) begin
      c.output_active[i] = c.output_enable[i] & c.chip_enable & lock_ok;
      if (i <= `CCR_GROUP0_LAST) begin
        c.output_active[i] = c.output_active[i] & c.group0_divider_enable;
      end
    end
    cfg_out_next = c;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_out_reg <= '0;
      sda_out_reg <= 1'b0;
    end else begin
      cfg_out_reg <= cfg_out_next;
      sda_out_reg <= 1'b0;
    end
  end

  // Open-drain: the pad only ever pulls low
  assign sda_out = sda_out_reg;
  assign sda_oe = oe_reg;
  assign cfg_out = cfg_out_reg;

endmodule

`default_nettype wire

// ==== ccr_chk.sv ====
`default_nettype none
module ccr_chk
  import ccr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic pll_lock_in,
  input wire ccr_cfg_s cfg_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] P_TAB [16] = '{7'h01, 7'h02, 7'h04, 7'h05, 7'h08, 7'h0a, 7'h10,
    7'h14, 7'h20, 7'h28, 7'h50, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
  logic live_reg, live_next, gate, g0;
  ccr_cfg_s c;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // Helpers
  // Decoded fields still read zero on the first edge out of reset
  always_comb live_next = ~sys_rst;
  always_ff @(posedge sys_clk) live_reg <= live_next;
  always_comb c = cfg_out;
  always_comb gate = c.chip_enable & (c.lock_status | c.lock_gate_override);
  always_comb g0 = gate & c.group0_divider_enable;
  // ==========
  // Assertions
  chk_quiet_mode: assert property (
    live_reg |-> c.quiescent_powerdown == !c.chip_enable) else $error("bad power-down");
  chk_gate_upper: assert property (
    live_reg |-> c.output_active[10:5] == (c.output_enable[10:5] & {6{gate}}))
    else $error("bad upper gating");
  chk_gate_group0: assert property (
    live_reg |-> c.output_active[4:0] == (c.output_enable[4:0] & {5{g0}}))
    else $error("bad group 0 gating");
  chk_ext_filter: assert property (
    live_reg |-> c.external_loop_filter == (c.loop_bandwidth_select == 4'h1))
    else $error("bad filter flag");
  chk_in_ratio: assert property (
    live_reg |-> c.input_ratio == (4'h1 << c.input_divider_select)) else $error("bad in ratio");
  chk_fb_ratio: assert property (
    live_reg && c.feedback_divider_select[3:1] == 3'h4
      |-> c.feedback_ratio == (c.feedback_divider_select[0] ? 6'h28 : 6'h20))
    else $error("bad fb ratio");
  chk_post_ratio: assert property (
    live_reg |-> c.group0_ratio == P_TAB[c.group0_ratio_select]) else $error("bad ratio");
  chk_lock_seen: assert property (
    $rose(pll_lock_in) |-> ##[1:8] c.lock_status) else $error("lock not seen");
  cover property (scl_in && $fell(sda_in));
  cover property (sda_oe && scl_in && !sda_out);
  cover property (live_reg && c.external_loop_filter);
endmodule
`default_nettype wire

// ==== ccr_host.sv ====
`default_nettype none
module ccr_host (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl_line = 1'b1,
  output logic sda_low = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] dev_addr = 7'h2a;
  // ==========
  // Bus steps
  // Halves of 10 cycles stay clear of the device's input synchronisers
  task automatic hw(input logic s, input logic d, input int n);
    scl_line = s;
    sda_low = d;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // The ninth bit m is what the host puts out: 1 releases, 0 acknowledges
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q,
    output logic a);
    logic [8:0] w;
    w = {d, m};
    for (int i = 8; i >= 0; i--) begin
      hw(1'b0, !w[i], 5);
      hw(1'b1, !w[i], 5);
      w[i] = sda_line;
      hw(1'b1, sda_low, 5);
      hw(1'b0, sda_low, 5);
    end
    {q, a} = w;
  endtask
  task automatic start;
    hw(1'b0, 1'b0, 5);
    hw(1'b1, 1'b0, 10);
    hw(1'b1, 1'b1, 10);
    hw(1'b0, 1'b1, 5);
  endtask
  task automatic stop;
    hw(1'b0, 1'b1, 5);
    hw(1'b1, 1'b1, 10);
    hw(1'b1, 1'b0, 10);
  endtask
  // Reads end with a released ninth bit, the master's refusal; word reads ACK the low byte
  task automatic xact(input logic rd, input logic two, input logic [2:0] k,
    input logic [15:0] d, output logic [15:0] q, output logic ok);
    logic [3:0] a;
    logic [7:0] x;
    logic n;
    q = 16'h0000;
    a = 4'h0;
    start;
    xfer({dev_addr, 1'b0}, 1'b1, x, a[0]);
    xfer({5'h10, k}, 1'b1, x, a[1]);
    if (rd) begin
      start;
      xfer({dev_addr, 1'b1}, 1'b1, x, a[2]);
      xfer(8'hff, ~two, q[7:0], n);
      if (two) xfer(8'hff, 1'b1, q[15:8], n);
    end else begin
      xfer(d[7:0], 1'b1, x, a[2]);
      if (two) xfer(d[15:8], 1'b1, x, a[3]);
    end
    stop;
    ok = ~|a;
  endtask
  task automatic txn(input logic rd, input logic [2:0] k, input logic [7:0] d,
    output logic [7:0] q, output logic ok);
    logic [15:0] w;
    xact(rd, 1'b0, k, {8'h00, d}, w, ok);
    q = w[7:0];
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pll_lock_in = 1'b0;
  logic scl_line, sda_low, sda_out, sda_oe, ok;
  logic [7:0] rv;
  logic [15:0] wv;
  ccr_pkg::ccr_cfg_s cfg;
  int fail_count = 0;
  int check_count = 0;
  logic [7:0] rst_tab [3:7] = '{8'h00, 8'h27, 8'hff, 8'hf0, 8'h89};
  logic [6:0] rt [11] = '{7'h01, 7'h02, 7'h04, 7'h05, 7'h08, 7'h0a, 7'h10, 7'h14,
    7'h20, 7'h28, 7'h50};
  // Pulled-up line: whoever enables a driver shows its value, so sda_out is seen
  wire logic sda_line = ~sda_low & (~sda_oe | sda_out);
  always #10 sys_clk = ~sys_clk;
  ccr_config_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl_line),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .pll_lock_in(pll_lock_in),
    .cfg_out(cfg));
  ccr_host host (.sys_clk(sys_clk), .sda_line(sda_line), .scl_line(scl_line),
    .sda_low(sda_low));
  // ==========
  // Shared steps
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] k, input logic [7:0] d);
    host.txn(1'b0, k, d, rv, ok);
    check(ok, 1'b1);
  endtask
  task automatic rd(input logic [2:0] k, input logic [7:0] e);
    host.txn(1'b1, k, 8'h00, rv, ok);
    check({ok, rv}, {1'b1, e});
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    check({cfg.lock_gate_override, cfg.group0_phase_select}, 6'h00);
    check({cfg.group0_divider_enable, cfg.group0_bypass}, 2'h2);
    check({cfg.group0_ratio_select, cfg.group0_ratio}, {4'h7, 7'h14});
    check({cfg.chip_enable, cfg.output_enable, cfg.synth_loop_enable}, 13'h1fff);
    check({cfg.loop_bandwidth_select, cfg.input_divider_select}, 6'h00);
    check({cfg.feedback_divider_select, cfg.feedback_ratio}, {4'h9, 6'h28});
    for (int k = 3; k < 8; k++) rd(3'(k), rst_tab[k]);
  endtask
  task automatic t_write;
    wr(3'h3, 8'h3f);
    wr(3'h4, 8'h1a);
    wr(3'h5, 8'h55);
    wr(3'h6, 8'ha1);
    wr(3'h7, 8'h38);
    check({cfg.lock_gate_override, cfg.group0_phase_select}, 6'h3f);
    check({cfg.group0_divider_enable, cfg.group0_bypass, cfg.group0_ratio}, 9'h0d0);
    check({cfg.chip_enable, cfg.quiescent_powerdown, cfg.output_active}, 13'h0800);
    check(cfg.output_enable, 11'h55a);
    check({cfg.loop_bandwidth_select, cfg.external_loop_filter}, 5'h03);
    check({cfg.synth_loop_enable, cfg.input_ratio, cfg.feedback_ratio}, 11'h220);
  endtask
  task automatic t_ratios;
    for (int c = 0; c < 11; c++) begin
      wr(3'h4, {4'h2, 4'(c)});
      check({cfg.group0_ratio_select, cfg.group0_ratio}, {4'(c), rt[c]});
    end
    for (int m = 0; m < 4; m++) begin
      wr(3'h7, {2'h2, 2'(m), 4'h9});
      check({cfg.input_ratio, cfg.feedback_ratio}, {4'h1 << m, 6'h28});
    end
  endtask
  task automatic t_gate;
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h27);
    wr(3'h5, 8'hff);
    wr(3'h6, 8'hf0);
    check({cfg.lock_status, cfg.output_active}, 12'h000);
    rd(3'h0, 8'h00);
    pll_lock_in = 1'b1;
    tick(10);
    check({cfg.lock_status, cfg.output_active}, 12'hfff);
    rd(3'h0, 8'h80);
    wr(3'h4, 8'h07);
    pll_lock_in = 1'b0;
    wr(3'h3, 8'h20);
    check({cfg.lock_status, cfg.output_active}, 12'h7e0);
    wr(3'h5, 8'h7f);
    check({cfg.quiescent_powerdown, cfg.output_active}, 12'h800);
    host.dev_addr = 7'h2b;
    host.txn(1'b0, 3'h3, 8'h15, rv, ok);
    check(ok, 1'b0);
    host.dev_addr = 7'h2a;
    wr(3'h1, 8'h15);
    rd(3'h1, 8'h00);
    rd(3'h3, 8'h20);
  endtask
  task automatic t_word;
    host.xact(1'b0, 1'b1, 3'h5, 16'h30d5, wv, ok);
    check(ok, 1'b1);
    check({cfg.chip_enable, cfg.output_enable}, 12'hd53);
    host.xact(1'b1, 1'b1, 3'h5, 16'h0000, wv, ok);
    check({ok, wv}, {1'b1, 16'h30d5});
  endtask
  // Mid-run reset must bring every field back to its power-up value
  task automatic t_rerun;
    sys_rst = 1'b1;
    tick(3);
    sys_rst = 1'b0;
    tick(6);
    check(sda_oe, 1'b0);
    t_reset;
  endtask
  initial begin
    tick(3);
    sys_rst = 1'b0;
    tick(6);
    t_reset;
    t_write;
    t_ratios;
    t_gate;
    t_word;
    t_rerun;
    report_and_stop;
  end
endmodule
bind ccr_config_regs ccr_chk chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .pll_lock_in(pll_lock_in),
  .cfg_out(cfg_out));
`default_nettype wire
